// file: rtl/spidg_port.sv
// Serial slave port that receives 40-bit command datagrams and returns replies.
module spidg_port
	import spidg_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Serial link pins.
	input wire logic sck,
	input wire logic sdi,
	input wire logic chip_select_low,
	output logic sdo,
	output logic sdo_oe,
	// Driver enable pin and its filtered level.
	input wire logic driver_enable_low,
	output logic driver_enable,
	// Received commands.
	output logic cmd_valid,
	input wire logic cmd_ready,
	output spidg_cmd_s cmd,
	output logic cmd_overrun,
	// Reply sources.
	input wire logic [7:0] status_in,
	output logic read_strobe,
	output logic [6:0] read_addr,
	input wire logic [31:0] read_data
);

	// Pin synchronisers and glitch filters.
	logic [PIN_N-1:0] sync1_q, sync2_q, filt_q, filt_d;
	logic [1:0] fcnt_q [PIN_N];
	logic [1:0] fcnt_d [PIN_N];
	logic sck_prev_q;

	always_comb begin
		filt_d = filt_q;
		for (int i = 0; i < PIN_N; i++) begin
			fcnt_d[i] = FCNT_ZERO;
			if (sync2_q[i] != filt_q[i]) begin
				// A level must be seen on two samples a filter time apart before it is believed.
				if (fcnt_q[i] >= FILT_CYC) begin
					filt_d[i] = sync2_q[i];
				end else begin
					fcnt_d[i] = fcnt_q[i] + FCNT_STEP;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_q <= PIN_RST;
			sync2_q <= PIN_RST;
			filt_q <= PIN_RST;
			sck_prev_q <= 1'b1;
			for (int i = 0; i < PIN_N; i++) begin
				fcnt_q[i] <= FCNT_ZERO;
			end
		end else begin
			sync1_q <= {driver_enable_low, chip_select_low, sdi, sck};
			sync2_q <= sync1_q;
			filt_q <= filt_d;
			sck_prev_q <= filt_q[PIN_SCK];
			fcnt_q <= fcnt_d;
		end
	end

	logic sel, sck_rise, sck_fall;

	// Clock edges only count while selected, so other slaves can share the bus.
	assign sel = !filt_q[PIN_CSN];
	assign sck_rise = sel && filt_q[PIN_SCK] && !sck_prev_q;
	assign sck_fall = sel && !filt_q[PIN_SCK] && sck_prev_q;
	assign driver_enable = !filt_q[PIN_ENN];

	// Link state, shift register and serial output.
	spidg_link_e state_q, state_d;
	logic [DGRAM_MSB:0] shift_q, shift_d, reply_q, reply_d;
	logic [5:0] bitcnt_q, bitcnt_d;
	logic sdo_q, sdo_d, oe_q, oe_d;
	logic new_cmd;

	// A datagram shorter than forty clocks is treated as aborted and dropped.
	assign new_cmd = state_q == LINK_SEL && !sel && bitcnt_q >= BITCNT_FULL;

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bitcnt_d = bitcnt_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		unique case (state_q)
			LINK_IDLE: begin
				if (sel) begin
					state_d = LINK_SEL;
					shift_d = reply_q;
					// Mode 3 needs the first bit valid before the first rising edge.
					sdo_d = reply_q[DGRAM_MSB];
					oe_d = 1'b1;
					bitcnt_d = BITCNT_ZERO;
				end
			end
			LINK_SEL: begin
				if (!sel) begin
					state_d = LINK_IDLE;
					oe_d = 1'b0;
				end else begin
					if (sck_rise) begin
						shift_d = {shift_q[DGRAM_MSB-1:0], filt_q[PIN_SDI]};
						if (bitcnt_q < BITCNT_FULL) begin
							bitcnt_d = bitcnt_q + BITCNT_STEP;
						end
					end
					if (sck_fall) begin
						// Bits beyond forty re-emerge here after a full pass.
						sdo_d = shift_q[DGRAM_MSB];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= LINK_IDLE;
			shift_q <= '0;
			bitcnt_q <= BITCNT_ZERO;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			bitcnt_q <= bitcnt_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = oe_q;

	// Command hand-off and reply preparation.
	spidg_cmd_s cmd_q, cmd_d;
	logic pend_q, pend_d, ovr_q, ovr_d, rd_q, rd_d;
	logic [6:0] raddr_q, raddr_d;
	logic buf_ready;

	always_comb begin
		cmd_d = cmd_q;
		pend_d = pend_q;
		reply_d = reply_q;
		rd_d = 1'b0;
		raddr_d = raddr_q;
		ovr_d = 1'b0;
		if (pend_q && buf_ready) begin
			pend_d = 1'b0;
		end
		if (rd_q) begin
			reply_d[DATA_MSB:0] = read_data;
		end
		if (new_cmd) begin
			// The shift register holds just the last forty bits that arrived.
			cmd_d = spidg_cmd_s'(shift_q);
			pend_d = 1'b1;
			// A full buffer with a command still waiting means the old one is lost.
			ovr_d = pend_q && !buf_ready;
			reply_d[STATUS_MSB:STATUS_LSB] = status_in;
			if (shift_q[WFLAG_POS]) begin
				reply_d[DATA_MSB:0] = shift_q[DATA_MSB:0];
			end else begin
				rd_d = 1'b1;
				raddr_d = shift_q[ADDR_MSB:ADDR_LSB];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_q <= CMD_RST;
			pend_q <= 1'b0;
			ovr_q <= 1'b0;
			rd_q <= 1'b0;
			raddr_q <= 7'h00;
			reply_q <= '0;
		end else begin
			cmd_q <= cmd_d;
			pend_q <= pend_d;
			ovr_q <= ovr_d;
			rd_q <= rd_d;
			raddr_q <= raddr_d;
			reply_q <= reply_d;
		end
	end

	assign cmd_overrun = ovr_q;
	assign read_strobe = rd_q;
	assign read_addr = raddr_q;

	spidg_buf #(
		.WIDTH($bits(spidg_cmd_s)),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clock(clock),
		.rst(rst),
		.in_valid(pend_q),
		.in_ready(buf_ready),
		.in_data(cmd_q),
		.out_valid(cmd_valid),
		.out_ready(cmd_ready),
		.out_data(cmd)
	);

	// Checks on the port's own behaviour.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_filter_follows;
		$changed(filt_q[PIN_SCK]) |-> filt_q[PIN_SCK] == $past(sync2_q[PIN_SCK]) &&
			filt_q[PIN_SCK] == $past(sync2_q[PIN_SCK], 2);
	endproperty
	a_filter_follows: assert property (p_filter_follows) else $error("Filter changed wrongly.");

	property p_sample_rise;
		sck_rise && state_q == LINK_SEL |=> shift_q[0] == $past(filt_q[PIN_SDI]);
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("Input not sampled on rise.");

	property p_out_fall;
		sck_fall && state_q == LINK_SEL |=> sdo == $past(shift_q[DGRAM_MSB]);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("Output not updated on fall.");

	property p_idle_hold;
		state_q == LINK_IDLE && !sel |=> shift_q == $past(shift_q) && !sdo_oe;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Activity while deselected.");

	property p_select_loads;
		state_q == LINK_IDLE && sel |=> sdo_oe && sdo == $past(reply_q[DGRAM_MSB]);
	endproperty
	a_select_loads: assert property (p_select_loads) else $error("First bit not presented.");

	property p_latch_cmd;
		new_cmd |=> pend_q && cmd_q == $past(shift_q) ##1 !sdo_oe;
	endproperty
	a_latch_cmd: assert property (p_latch_cmd) else $error("Command not latched.");

	property p_short_drop;
		state_q == LINK_SEL && !sel && bitcnt_q < BITCNT_FULL |=> cmd_q == $past(cmd_q);
	endproperty
	a_short_drop: assert property (p_short_drop) else $error("Short datagram latched.");

	property p_write_echo;
		new_cmd && shift_q[WFLAG_POS] |=> reply_q[DATA_MSB:0] == $past(shift_q[DATA_MSB:0]);
	endproperty
	a_write_echo: assert property (p_write_echo) else $error("Write data not echoed.");

	property p_read_reply;
		new_cmd && !shift_q[WFLAG_POS] |=> read_strobe ##1 reply_q[DATA_MSB:0] == $past(read_data);
	endproperty
	a_read_reply: assert property (p_read_reply) else $error("Read data not captured.");

	property p_status;
		new_cmd |=> reply_q[STATUS_MSB:STATUS_LSB] == $past(status_in);
	endproperty
	a_status: assert property (p_status) else $error("Status not latched.");

endmodule

// file: common/spidg_pkg.sv
// Shared constants and types for the serial datagram port.
package spidg_pkg;

	// Datagram layout.
	localparam int DGRAM_BITS = 40;
	localparam int DGRAM_MSB = 39;
	localparam int STATUS_MSB = 39;
	localparam int STATUS_LSB = 32;
	localparam int WFLAG_POS = 39;
	localparam int ADDR_MSB = 38;
	localparam int ADDR_LSB = 32;
	localparam int DATA_MSB = 31;
	localparam logic [5:0] BITCNT_FULL = 6'h28;
	localparam logic [5:0] BITCNT_ZERO = 6'h00;
	localparam logic [5:0] BITCNT_STEP = 6'h01;

	// Pin vector positions.
	localparam int PIN_N = 4;
	localparam int PIN_SCK = 0;
	localparam int PIN_SDI = 1;
	localparam int PIN_CSN = 2;
	localparam int PIN_ENN = 3;
	// Clock, select and enable idle high; data idles low.
	localparam logic [PIN_N-1:0] PIN_RST = 4'hD;

	// Input filter timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int FILT_NS = 20;
	localparam int FILT_CYC_I = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] FILT_CYC = (FILT_CYC_I < 1) ? 2'h1 : 2'(FILT_CYC_I);
	localparam logic [1:0] FCNT_ZERO = 2'h0;
	localparam logic [1:0] FCNT_STEP = 2'h1;

	typedef enum logic {
		LINK_IDLE = 1'b0,
		LINK_SEL = 1'b1
	} spidg_link_e;

	typedef struct packed {
		logic write_flag;
		logic [6:0] addr;
		logic [31:0] data;
	} spidg_cmd_s;

	localparam spidg_cmd_s CMD_RST = '{write_flag: 1'b0, addr: 7'h00, data: 32'h0000_0000};

endpackage

// file: rtl/spidg_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
module spidg_buf #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("Buffer depth must be a power of two of at least two.");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	always_comb begin
		in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
		out_valid = wr_q != rd_q;
		out_data = mem_q[rd_q[PW-1:0]];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? wr_q + (PW+1)'(1) : wr_q;
		rd_d = pop ? rd_q + (PW+1)'(1) : rd_q;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage needs no reset; the pointers guard every read.
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q[PW-1:0]] <= in_data;
		end
	end

endmodule

// file: tb/spidg_master.sv
// Behavioural serial bus master that drives datagrams into the port.
module spidg_master (
	// Pins driven by the master.
	output logic sck,
	output logic sdi,
	output logic chip_select_low,
	// Reply from the port.
	input wire logic sdo,
	input wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	// A 400 ns period is 2.5 MHz, well below half the system clock and the on-chip limit.
	// The low phase is longer so the filtered reply bit is settled before sampling.
	localparam int T_HI = 125;
	localparam int T_LO = 275;

	initial begin
		sck = 1'b1;
		sdi = 1'b0;
		chip_select_low = 1'b1;
	end

	task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx,
			output logic oe_ok);
		rx = '0;
		oe_ok = 1'b1;
		#13;
		chip_select_low = 1'b0;
		#400;
		for (int i = n - 1; i >= 0; i--) begin
			sck = 1'b0;
			sdi = tx[i];
			#(T_LO);
			sck = 1'b1;
			rx[i] = sdo;
			oe_ok = oe_ok & sdo_oe;
			#(T_HI);
		end
		chip_select_low = 1'b1;
		// A released data line must not keep the last bit, or a stale value could pass.
		sdi = ~sdi;
		#400;
	endtask

	// Clock edges while deselected, which a slave sharing the bus must ignore.
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			sck = 1'b0;
			sdi = ~sdi;
			#(T_LO);
			sck = 1'b1;
			#(T_HI);
		end
	endtask
endmodule

// file: tb/spi_slave_datagram_port_bench.sv
// Self-checking bench for the serial datagram port.
module spi_slave_datagram_port_bench import spidg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock, rst, sck, sdi, chip_select_low, sdo, sdo_oe;
	logic driver_enable_low, driver_enable, cmd_valid, cmd_ready, cmd_overrun, read_strobe;
	spidg_cmd_s cmd;
	logic [7:0] status_in;
	logic [6:0] read_addr;
	logic [31:0] read_data;
	int n_errors, n_tests, n_ovr, n_rd;

	spidg_port #(.BUF_DEPTH(2)) i_spidg_port (.clock(clock), .rst(rst), .sck(sck), .sdi(sdi),
		.chip_select_low(chip_select_low), .sdo(sdo), .sdo_oe(sdo_oe),
		.driver_enable_low(driver_enable_low), .driver_enable(driver_enable),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_overrun(cmd_overrun),
		.status_in(status_in), .read_strobe(read_strobe), .read_addr(read_addr),
		.read_data(read_data));

	spidg_master i_spidg_master (.sck(sck), .sdi(sdi), .chip_select_low(chip_select_low),
		.sdo(sdo), .sdo_oe(sdo_oe));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (cmd_overrun === 1'b1) n_ovr++;
		if (read_strobe === 1'b1) n_rd++;
	end

	task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		if (n_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// One whole selection; the reply and the enable are judged bit for bit.
	task automatic dg(input int n, input logic [47:0] tx, input logic [47:0] exp, string what);
		logic [47:0] rx;
		logic ok;
		i_spidg_master.xfer(n, tx, rx, ok);
		check(what, exp, rx);
		check("sdo_oe framed", 48'h1, {47'h0, ok});
		check("sdo_oe released", 48'h0, {47'h0, sdo_oe});
	endtask

	task automatic test_enable_filter;
		driver_enable_low <= 1'b0;
		repeat (8) @(negedge clock);
		check("driver_enable on", 48'h1, {47'h0, driver_enable});
		@(posedge clock);
		// The pulse straddles a clock edge, so a plain synchroniser would pass it.
		#40 driver_enable_low = 1'b1;
		#15 driver_enable_low = 1'b0;
		repeat (8) @(negedge clock);
		check("driver_enable glitch", 48'h1, {47'h0, driver_enable});
		@(posedge clock);
		driver_enable_low <= 1'b1;
		repeat (8) @(negedge clock);
		check("driver_enable off", 48'h0, {47'h0, driver_enable});
	endtask

	// With the sink stalled, four datagrams fill the buffer and overwrite the pending one.
	task automatic test_datagrams;
		@(posedge clock);
		status_in <= 8'h5A;
		read_data <= 32'hCAFE_F00D;
		dg(40, 48'h21_0000_0000, 48'h0, "reply after reset");
		check("read_addr", 48'h21, {41'h0, read_addr});
		@(posedge clock);
		status_in <= 8'hC3;
		dg(40, 48'hA7_00AB_CDEF, 48'h5A_CAFE_F00D, "reply to read");
		dg(40, 48'hA7_0012_3456, 48'hC3_00AB_CDEF, "write echo");
		i_spidg_master.idle_clocks(8);
		dg(8, 48'hFF, 48'hC3, "short datagram");
		dg(48, 48'h96_2C_1111_2222, 48'hC3_0012_3456_96, "daisy chain");
		check("overrun pulses", 48'h1, 48'(n_ovr));
		check("read strobes", 48'h2, 48'(n_rd));
		check("read_addr last", 48'h2C, {41'h0, read_addr});
	endtask

	task automatic test_drain;
		logic [39:0] exp [3];
		int k;
		exp[0] = 40'h21_0000_0000;
		exp[1] = 40'hA7_00AB_CDEF;
		exp[2] = 40'h2C_1111_2222;
		k = 0;
		@(posedge clock);
		cmd_ready <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(negedge clock);
			if (cmd_valid === 1'b1 && k < 3) begin
				check("command", {8'h0, exp[k]}, {8'h0, cmd});
				k++;
			end
		end
		check("commands drained", 48'h3, 48'(k));
		check("cmd_valid empty", 48'h0, {47'h0, cmd_valid});
	endtask

	initial begin
		n_errors = 0;
		n_tests = 0;
		n_ovr = 0;
		n_rd = 0;
		rst = 1'b1;
		driver_enable_low = 1'b1;
		cmd_ready = 1'b0;
		status_in = 8'h00;
		read_data = 32'h0000_0000;
		repeat (16) @(posedge clock);
		@(negedge clock);
		check("reset outputs", 48'h0, {44'h0, sdo_oe, cmd_valid, read_strobe, driver_enable});
		@(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		test_enable_filter;
		test_datagrams;
		test_drain;
		give_verdict;
	end
endmodule
